// File: scb_defs.vh
// Constants for the system control register bank.
`ifndef SCB_DEFS_VH
`define SCB_DEFS_VH
// ==========================================================
// Register placement and reset
`define SCB_OFFSET 8'h80
`define SCB_RESET 32'h08449060
// Bits that software may write; everything else is read-only or write-one-clear.
`define SCB_RW_MASK 32'hCD7FC000
// Lower bits are not implemented here and read back their default value.
`define SCB_LOW_MASK 32'h00003FFF
// ==========================================================
// Field positions
`define SCB_STEP_HI 31
`define SCB_STEP_LO 30
`define SCB_RSVD29 29
`define SCB_RSVD28 28
`define SCB_OSC_ON 27
`define SCB_IRQ_SELECT 26
`define SCB_WR_FLAG 25
`define SCB_WR_ENABLE 24
`define SCB_RSVD23 23
`define SCB_SPARE_DRIVE 22
`define SCB_GUARD_DISABLE 21
`define SCB_VIDEO_TRIM 20
`define SCB_KEEP_HI 19
`define SCB_KEEP_LO 16
`define SCB_DOWN_BURST 15
`define SCB_UP_BURST 14
// ==========================================================
// Serialized interrupt slot codes
`define SCB_SLOT_SECOND 2'h1
`define SCB_SLOT_THIRD 2'h2
`define SCB_SLOT_FOURTH 2'h3
`endif

// File: scb_sync.v
// Two-flop synchroniser for a level coming from a pin.
`timescale 1ns/1ps
module scb_sync (
	input wire clk,
	input wire rst_n,
	input wire async_in,
	output wire sync_out
);
	reg meta_reg;
	reg sync_reg;
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end
	assign sync_out = sync_reg;
endmodule // scb_sync

// File: scb_system_control.v
// System control register bank, upper bits 31 to 14, on the configuration port.
// How it works
// - Register at offset 80h, default 08449060h.
// - Bits 31:30 pick the serial interrupt slot.
// - Bit 28 always reads zero.
// - Bit 27 enables oscillator, resets to one.
// - Bit 26 routes power-write interrupt: line2/status-change.
// - Flag 25 sets on enabled power write.
// - Writing one clears flag 25; zero keeps.
// - Bit 24 enables interrupt on power write.
// - Bit 23 always reads zero.
// - Bit 22 drives spare CardBus terminals low while a CardBus card is present.
// - Bit 21 set turns supply protection off.
// - Bit 20 floats address A25..A22 for 16-bit.
// - Bit 15 allows downstream memory read bursts.
// - Bit 14 allows upstream memory read bursts.
`timescale 1ns/1ps
`include "scb_defs.vh"
module scb_system_control (
	input wire clk,
	input wire rst_n,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output wire [31:0] cfg_rdata,
	input wire power_write_evt,
	input wire cardbus_present,
	output wire [1:0] irq_serial_slot,
	output wire osc_on,
	output wire irq2_pulse,
	output wire card_status_change_irq,
	output wire power_write_smi,
	output wire spare_term_out,
	output wire spare_term_oe,
	output wire supply_guard_on,
	output wire addr_hi_float,
	output wire downstream_read_burst,
	output wire upstream_read_burst
);
	// ==========================================================
	// Configuration access decode
	localparam [31:0] RESET_WORD = `SCB_RESET;
	localparam [31:0] LOW_WORD = `SCB_RESET & `SCB_LOW_MASK;
	wire hit;
	wire [3:0] lane_wr;
	wire clear_req;
	wire fire;
	wire cardbus_sync;
	reg [1:0] step_reg;
	reg [1:0] step_next;
	reg osc_reg;
	reg osc_next;
	reg route_reg;
	reg route_next;
	reg smi_en_reg;
	reg smi_en_next;
	reg flag_reg;
	reg flag_next;
	reg spare_reg;
	reg spare_next;
	reg guard_off_reg;
	reg guard_off_next;
	reg trim_reg;
	reg trim_next;
	reg [3:0] keep_reg;
	reg [3:0] keep_next;
	reg down_reg;
	reg down_next;
	reg up_reg;
	reg up_next;
	reg [1:0] slot_reg;
	reg [1:0] slot_next;
	reg [31:0] read_word;
	reg [31:0] rdata_reg;
	reg irq2_reg;
	reg csc_reg;
	reg smi_reg;

	assign hit = (cfg_addr == `SCB_OFFSET);
	// Apart from flag 25 setting on a power write, only a write that hits moves a field, and only in the byte lanes it enables.
	assign lane_wr = {4{cfg_wr & hit}} & cfg_be;
	assign clear_req = lane_wr[3] & cfg_wdata[`SCB_WR_FLAG];
	assign fire = power_write_evt & smi_en_reg;

	// ==========================================================
	// Lane 3: slot step, oscillator, routing and interrupt enable
	always @* begin
		step_next = step_reg;
		osc_next = osc_reg;
		route_next = route_reg;
		smi_en_next = smi_en_reg;
		if (lane_wr[3]) begin
			step_next = cfg_wdata[`SCB_STEP_HI:`SCB_STEP_LO];
			osc_next = cfg_wdata[`SCB_OSC_ON];
			route_next = cfg_wdata[`SCB_IRQ_SELECT];
			smi_en_next = cfg_wdata[`SCB_WR_ENABLE];
		end
	end

	// ==========================================================
	// Sticky power-write flag
	// A new event beats a clear in the same cycle, so no enabled power write goes unreported.
	always @* begin
		flag_next = flag_reg;
		if (clear_req) begin
			flag_next = 1'b0;
		end
		if (fire) begin
			flag_next = 1'b1;
		end
	end

	// ==========================================================
	// Lane 2: spare terminals, supply guard, video trim, kept bits
	always @* begin
		spare_next = spare_reg;
		guard_off_next = guard_off_reg;
		trim_next = trim_reg;
		keep_next = keep_reg;
		if (lane_wr[2]) begin
			spare_next = cfg_wdata[`SCB_SPARE_DRIVE];
			guard_off_next = cfg_wdata[`SCB_GUARD_DISABLE];
			trim_next = cfg_wdata[`SCB_VIDEO_TRIM];
			keep_next = cfg_wdata[`SCB_KEEP_HI:`SCB_KEEP_LO];
		end
	end

	// ==========================================================
	// Lane 1: memory read bursting
	always @* begin
		down_next = down_reg;
		up_next = up_reg;
		if (lane_wr[1]) begin
			down_next = cfg_wdata[`SCB_DOWN_BURST];
			up_next = cfg_wdata[`SCB_UP_BURST];
		end
	end

	// ==========================================================
	// Serial interrupt slot decode
	// Codes 00 and 01 both land in the second slot. Decoding the next value keeps the
	// registered slot output in step with the field itself.
	always @* begin
		case (step_next)
			2'h0: slot_next = `SCB_SLOT_SECOND;
			2'h1: slot_next = `SCB_SLOT_SECOND;
			2'h2: slot_next = `SCB_SLOT_THIRD;
			2'h3: slot_next = `SCB_SLOT_FOURTH;
			default: slot_next = `SCB_SLOT_SECOND;
		endcase
	end

	// ==========================================================
	// Read word
	// Reserved bits 29, 28 and 23 stay zero; the lower bits are not kept here and
	// show their default.
	always @* begin
		read_word = LOW_WORD;
		read_word[`SCB_STEP_HI:`SCB_STEP_LO] = step_reg;
		read_word[`SCB_RSVD29] = 1'b0;
		read_word[`SCB_RSVD28] = 1'b0;
		read_word[`SCB_OSC_ON] = osc_reg;
		read_word[`SCB_IRQ_SELECT] = route_reg;
		read_word[`SCB_WR_FLAG] = flag_reg;
		read_word[`SCB_WR_ENABLE] = smi_en_reg;
		read_word[`SCB_RSVD23] = 1'b0;
		read_word[`SCB_SPARE_DRIVE] = spare_reg;
		read_word[`SCB_GUARD_DISABLE] = guard_off_reg;
		read_word[`SCB_VIDEO_TRIM] = trim_reg;
		read_word[`SCB_KEEP_HI:`SCB_KEEP_LO] = keep_reg;
		read_word[`SCB_DOWN_BURST] = down_reg;
		read_word[`SCB_UP_BURST] = up_reg;
	end

	// ==========================================================
	// Registers
	always @(posedge clk) begin
		if (!rst_n) begin
			step_reg <= RESET_WORD[`SCB_STEP_HI:`SCB_STEP_LO];
			osc_reg <= RESET_WORD[`SCB_OSC_ON];
			route_reg <= RESET_WORD[`SCB_IRQ_SELECT];
			smi_en_reg <= RESET_WORD[`SCB_WR_ENABLE];
			flag_reg <= RESET_WORD[`SCB_WR_FLAG];
			spare_reg <= RESET_WORD[`SCB_SPARE_DRIVE];
			guard_off_reg <= RESET_WORD[`SCB_GUARD_DISABLE];
			trim_reg <= RESET_WORD[`SCB_VIDEO_TRIM];
			keep_reg <= RESET_WORD[`SCB_KEEP_HI:`SCB_KEEP_LO];
			down_reg <= RESET_WORD[`SCB_DOWN_BURST];
			up_reg <= RESET_WORD[`SCB_UP_BURST];
			slot_reg <= `SCB_SLOT_SECOND;
			rdata_reg <= 32'h00000000;
			irq2_reg <= 1'b0;
			csc_reg <= 1'b0;
			smi_reg <= 1'b0;
		end else begin
			step_reg <= step_next;
			osc_reg <= osc_next;
			route_reg <= route_next;
			smi_en_reg <= smi_en_next;
			flag_reg <= flag_next;
			spare_reg <= spare_next;
			guard_off_reg <= guard_off_next;
			trim_reg <= trim_next;
			keep_reg <= keep_next;
			down_reg <= down_next;
			up_reg <= up_next;
			slot_reg <= slot_next;
			if (cfg_rd) begin
				rdata_reg <= hit ? read_word : 32'h00000000;
			end
			smi_reg <= fire;
			irq2_reg <= fire & ~route_reg;
			csc_reg <= fire & route_reg;
		end
	end

	// ==========================================================
	// Card-side controls
	scb_sync u_cardbus_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(cardbus_present),
		.sync_out(cardbus_sync)
	);

	// The spare terminals are only ever pulled low, so the drive value is fixed.
	assign spare_term_out = 1'b0;
	assign spare_term_oe = cardbus_sync & spare_reg;
	assign irq_serial_slot = slot_reg;
	assign osc_on = osc_reg;
	assign supply_guard_on = ~guard_off_reg;
	assign addr_hi_float = trim_reg;
	assign downstream_read_burst = down_reg;
	assign upstream_read_burst = up_reg;
	assign cfg_rdata = rdata_reg;
	assign irq2_pulse = irq2_reg;
	assign card_status_change_irq = csc_reg;
	assign power_write_smi = smi_reg;
endmodule // scb_system_control

// File: scb_checker.sv
// Assertion checker for the system control register bank.
`timescale 1ns/1ps
module scb_checker(
	input wire clk,
	input wire rst_n,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire power_write_evt,
	input wire irq2_pulse,
	input wire card_status_change_irq,
	input wire power_write_smi,
	input wire osc_on,
	input wire supply_guard_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_route; power_write_smi |-> irq2_pulse != card_status_change_irq; endproperty
	a_route: assert property (p_route) else $error("bad route");
	property p_fire; power_write_smi |-> $past(power_write_evt); endproperty
	a_fire: assert property (p_fire) else $error("stray pulse");
	property p_miss; cfg_rd && cfg_addr != 8'h80 |=> cfg_rdata == 32'h0; endproperty
	a_miss: assert property (p_miss) else $error("unmapped");
	property p_rsvd; cfg_rd |=> !cfg_rdata[28] && !cfg_rdata[23]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved");
	property p_low; cfg_rd && cfg_addr == 8'h80 |=> cfg_rdata[13:0] == 14'h1060; endproperty
	a_low: assert property (p_low) else $error("low bits");
	property p_osc; cfg_wr && cfg_addr == 8'h80 && cfg_be[3] |=> osc_on == $past(cfg_wdata[27]);
	endproperty
	a_osc: assert property (p_osc) else $error("osc");
	property p_guard; cfg_wr && cfg_addr == 8'h80 && cfg_be[2] |=> supply_guard_on != $past(cfg_wdata[21]);
	endproperty
	a_guard: assert property (p_guard) else $error("guard");
	property p_lane; cfg_wr && !cfg_be[3] |=> $stable(osc_on); endproperty
	a_lane: assert property (p_lane) else $error("lane");
	c_irq2: cover property (irq2_pulse);
	c_csc: cover property (card_status_change_irq);
	c_full: cover property (cfg_wr && cfg_be == 4'hF);
endmodule // scb_checker
bind scb_system_control scb_checker u_chk(
	.clk(clk),
	.rst_n(rst_n),
	.cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd),
	.cfg_addr(cfg_addr),
	.cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata),
	.power_write_evt(power_write_evt),
	.irq2_pulse(irq2_pulse),
	.card_status_change_irq(card_status_change_irq),
	.power_write_smi(power_write_smi),
	.osc_on(osc_on),
	.supply_guard_on(supply_guard_on)
);

// File: scb_host.sv
// Host configuration software model driving the register port.
`timescale 1ns/1ps
module scb_host(
	input wire clk,
	output reg cfg_wr,
	output reg cfg_rd,
	output reg [7:0] cfg_addr,
	output reg [3:0] cfg_be,
	output reg [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata
);
	initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = 0;
	task xfer(input w, input [7:0] a, input [3:0] be, input [31:0] d); begin
		@(posedge clk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_be} <= {w, !w, a, be};
		cfg_wdata <= (d & 32'hFFF0FFFF) | 32'h00040000;
		@(posedge clk);
		{cfg_wr, cfg_rd} <= 2'h0;
		cfg_wdata <= ~d;
		#1;
	end endtask
endmodule // scb_host

// File: system_control_upper_bits_test.sv
// Self-checking bench for the system control register bank.
`timescale 1ns/1ps
module system_control_upper_bits_test;
	reg clk = 0, rst_n = 0, power_write_evt = 0, cardbus_present = 0;
	wire cfg_wr, cfg_rd, osc_on, irq2_pulse, card_status_change_irq, power_write_smi;
	wire spare_term_out, spare_term_oe, supply_guard_on, addr_hi_float;
	wire downstream_read_burst, upstream_read_burst;
	wire [1:0] irq_serial_slot;
	wire [7:0] cfg_addr;
	wire [3:0] cfg_be;
	wire [31:0] cfg_wdata, cfg_rdata;
	integer n_fail = 0, n_checks = 0, i;
	always #20 clk = ~clk;
	scb_system_control uut(
		.clk(clk),
		.rst_n(rst_n),
		.cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata),
		.power_write_evt(power_write_evt),
		.cardbus_present(cardbus_present),
		.irq_serial_slot(irq_serial_slot),
		.osc_on(osc_on),
		.irq2_pulse(irq2_pulse),
		.card_status_change_irq(card_status_change_irq),
		.power_write_smi(power_write_smi),
		.spare_term_out(spare_term_out),
		.spare_term_oe(spare_term_oe),
		.supply_guard_on(supply_guard_on),
		.addr_hi_float(addr_hi_float),
		.downstream_read_burst(downstream_read_burst),
		.upstream_read_burst(upstream_read_burst)
	);
	scb_host host(
		.clk(clk),
		.cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr),
		.cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata)
	);
	task chk(input [31:0] got, input [31:0] exp); begin
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	end endtask
	task rd(input [31:0] e); begin
		host.xfer(0, 8'h80, 4'h0, 0);
		chk(cfg_rdata, e);
	end endtask
	task pulse; begin
		@(posedge clk) power_write_evt <= 1;
		@(posedge clk) power_write_evt <= 0;
		#1;
	end endtask
	task end_sim; begin
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end endtask
	task t_reset; begin
		rd(32'h08449060);
		chk({osc_on, supply_guard_on, downstream_read_burst, upstream_read_burst}, 4'hE);
		chk({irq_serial_slot, spare_term_oe, addr_hi_float, power_write_smi}, 5'h08);
		$display("reset done");
	end endtask
	task t_write; begin
		host.xfer(1, 8'h84, 4'hF, 0);
		host.xfer(0, 8'h84, 4'h0, 0);
		chk(cfg_rdata, 0);
		host.xfer(1, 8'h80, 4'hF, 32'hFFFFFFFF);
		@(posedge clk) cardbus_present <= 1;
		rd(32'hCD74D060);
		chk({irq_serial_slot, osc_on, supply_guard_on, addr_hi_float, spare_term_oe,
			spare_term_out, upstream_read_burst}, 8'hED);
		for (i = 0; i < 4; i = i + 1) begin
			host.xfer(1, 8'h80, 4'h8, i << 30);
			chk(irq_serial_slot, (i == 0) ? 1 : i);
		end
		rd(32'hC074D060);
		host.xfer(1, 8'h80, 4'h6, 32'h00000000);
		chk({downstream_read_burst, upstream_read_burst, spare_term_oe, supply_guard_on,
			addr_hi_float}, 5'h02);
		rd(32'hC0041060);
		host.xfer(1, 8'h80, 4'h6, 32'h0074C000);
		$display("write done");
	end endtask
	task t_event; begin
		pulse;
		chk({power_write_smi, irq2_pulse, card_status_change_irq}, 0);
		host.xfer(1, 8'h80, 4'h8, 32'h01000000);
		pulse;
		chk({power_write_smi, irq2_pulse, card_status_change_irq}, 6);
		rd(32'h0374D060);
		host.xfer(1, 8'h80, 4'h8, 32'h07000000);
		rd(32'h0574D060);
		pulse;
		chk({power_write_smi, irq2_pulse, card_status_change_irq}, 5);
		host.xfer(1, 8'h80, 4'h8, 32'h05000000);
		rd(32'h0774D060);
		fork
			host.xfer(1, 8'h80, 4'h8, 32'h07000000);
			pulse;
		join
		rd(32'h0774D060);
		$display("event done");
	end endtask
	task t_rerst; begin
		@(posedge clk) rst_n <= 0;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		rd(32'h08449060);
		chk({irq_serial_slot, spare_term_oe, addr_hi_float}, 4'h6);
		$display("rerst done");
	end endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_write;
		t_event;
		t_rerst;
		end_sim;
	end
endmodule // system_control_upper_bits_test
